// [hw/ecx_ext_control.sv]
// extended control, service interrupt and readback logic of the parallel port
`timescale 1ns/1ps
module ecx_ext_control #(
   parameter int FIFO_DEPTH = 16,
   parameter int LW = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic periph_error_n,
   input wire logic ack_irq_event,
   input wire logic dma_tc,
   input wire logic direction,
   input wire logic [LW-1:0] fifo_level,
   output logic irq_req,
   output logic dma_enable_out,
   output ecx_pkg::ecx_port_t port_ctl,
   output ecx_pkg::ecx_mode_t mode_out
);

   typedef struct packed {
      ecx_pkg::ecx_ecr_t ecr;
      ecx_pkg::ecx_setup_t setup;
      logic fault_prev;
      logic irq_req;
      logic dma_en;
      ecx_pkg::ecx_port_t port;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } ecx_state_t;

   localparam logic [LW-1:0] DEPTH = LW'(FIFO_DEPTH);

   ecx_state_t st;
   ecx_state_t next_st;

   logic setup_ph;
   logic wr_done;
   logic hit_ecr;
   logic hit_setup;
   logic hit_cfga;
   logic hit_cfgb;
   logic in_cfg;
   logic fifo_mode;
   logic [LW-1:0] free_bytes;
   logic svc_cond;
   logic svc_evt;
   logic fault_evt;
   logic fault_clr_evt;
   logic [2:0] irq_code;
   logic [2:0] dma_code;
   logic [7:0] ecr_rd;
   logic [7:0] cfgb_rd;

   assign setup_ph = psel && !penable;
   assign wr_done = psel && penable && st.ready && pwrite;
   assign hit_ecr = paddr == ecx_pkg::ADDR_ECR;
   assign hit_setup = paddr == ecx_pkg::ADDR_SETUP;
   assign in_cfg = st.ecr.mode == ecx_pkg::ECX_MODE_CFG;
   assign hit_cfga = in_cfg && paddr == ecx_pkg::ADDR_CFG_A;
   assign hit_cfgb = in_cfg && paddr == ecx_pkg::ADDR_CFG_B;
   assign fifo_mode = st.ecr.mode == ecx_pkg::ECX_MODE_FIFO
      || st.ecr.mode == ecx_pkg::ECX_MODE_ECP
      || st.ecr.mode == ecx_pkg::ECX_MODE_TEST;
   assign free_bytes = DEPTH - fifo_level;

   always_comb begin
      if (st.ecr.dma_permit) begin
         svc_cond = dma_tc;
      end else if (direction) begin
         svc_cond = fifo_level >= st.setup.rx_fill_threshold;
      end else begin
         svc_cond = free_bytes >= st.setup.tx_free_threshold;
      end
   end

   assign svc_evt = fifo_mode && !st.ecr.svc_irq_flag && svc_cond;
   assign fault_evt = st.ecr.mode == ecx_pkg::ECX_MODE_ECP && !st.ecr.fault_irq_disable_n
      && st.fault_prev && !periph_error_n;
   assign fault_clr_evt = st.ecr.mode == ecx_pkg::ECX_MODE_ECP && wr_done && hit_ecr
      && st.ecr.fault_irq_disable_n && !pwdata[ecx_pkg::ECR_FAULT_BIT] && !periph_error_n;

   always_comb begin
      case (st.setup.irq_sel)
         4'hF: irq_code = 3'h6;
         4'hE: irq_code = 3'h5;
         4'hB: irq_code = 3'h4;
         4'hA: irq_code = 3'h3;
         4'h9: irq_code = 3'h2;
         4'h7: irq_code = 3'h1;
         4'h5: irq_code = 3'h7;
         default: irq_code = 3'h0;
      endcase
      case (st.setup.dma_sel)
         2'h3: dma_code = 3'h3;
         2'h2: dma_code = 3'h2;
         2'h1: dma_code = 3'h1;
         default: dma_code = 3'h0;
      endcase
   end

   assign cfgb_rd = {1'b0, st.irq_req, irq_code, dma_code};
   assign ecr_rd = {st.ecr, fifo_level >= DEPTH, fifo_level == '0};

   always_comb begin
      next_st = st;
      next_st.fault_prev = periph_error_n;
      next_st.ready = setup_ph;
      next_st.slverr = 1'b0;
      if (setup_ph) begin
         next_st.rdata = '0;
         if (hit_ecr) begin
            next_st.rdata = {24'h0, ecr_rd};
         end else if (hit_setup) begin
            next_st.rdata = {7'h0, st.setup.epp_option_cfg, 2'h0, st.setup.dma_sel,
               st.setup.irq_sel, 3'h0, st.setup.rx_fill_threshold, 3'h0,
               st.setup.tx_free_threshold};
         end else if (hit_cfga) begin
            next_st.rdata = {24'h0, ecx_pkg::CFG_A_VALUE};
         end else if (hit_cfgb) begin
            next_st.rdata = {24'h0, cfgb_rd};
         end else begin
            next_st.slverr = 1'b1;
         end
      end
      if (wr_done && hit_ecr) begin
         next_st.ecr.mode = ecx_pkg::ecx_mode_t'(pwdata[7:5]);
         next_st.ecr.fault_irq_disable_n = pwdata[ecx_pkg::ECR_FAULT_BIT];
         next_st.ecr.dma_permit = pwdata[ecx_pkg::ECR_DMA_BIT];
         next_st.ecr.svc_irq_flag = pwdata[ecx_pkg::ECR_SVC_BIT];
      end
      if (wr_done && hit_setup) begin
         next_st.setup.tx_free_threshold = pwdata[ecx_pkg::SET_TX_LSB +: 5];
         next_st.setup.rx_fill_threshold = pwdata[ecx_pkg::SET_RX_LSB +: 5];
         next_st.setup.irq_sel = pwdata[ecx_pkg::SET_IRQ_LSB +: 4];
         next_st.setup.dma_sel = pwdata[ecx_pkg::SET_DMA_LSB +: 2];
         next_st.setup.epp_option_cfg = pwdata[ecx_pkg::SET_EPP_BIT];
      end
      if (svc_evt) begin
         next_st.ecr.svc_irq_flag = 1'b1;
      end
      next_st.irq_req = svc_evt || fault_evt || fault_clr_evt || ack_irq_event;
      next_st.dma_en = fifo_mode && st.ecr.dma_permit && !st.ecr.svc_irq_flag;
      next_st.port.ctrl_open_drain = st.ecr.mode == ecx_pkg::ECX_MODE_STD;
      next_st.port.fifo_reset_hold = !fifo_mode;
      next_st.port.data_tristate = direction && st.ecr.mode != ecx_pkg::ECX_MODE_STD
         && st.ecr.mode != ecx_pkg::ECX_MODE_FIFO;
      next_st.port.data_read_pins = st.ecr.mode == ecx_pkg::ECX_MODE_BIDIR;
      next_st.port.auto_tx_compat = st.ecr.mode == ecx_pkg::ECX_MODE_FIFO && !direction;
      next_st.port.auto_tx_ecp = st.ecr.mode == ecx_pkg::ECX_MODE_ECP && !direction;
      next_st.port.ecp_rev_pack = st.ecr.mode == ecx_pkg::ECX_MODE_ECP && direction;
      next_st.port.epp_active = st.ecr.mode == ecx_pkg::ECX_MODE_EPP
         && st.setup.epp_option_cfg;
      next_st.port.test_fifo = st.ecr.mode == ecx_pkg::ECX_MODE_TEST;
      next_st.port.cfg_mapped = in_cfg;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st.ecr <= ecx_pkg::ECR_RESET;
         st.setup <= '{tx_free_threshold: ecx_pkg::THRESHOLD_RESET,
            rx_fill_threshold: ecx_pkg::THRESHOLD_RESET,
            irq_sel: ecx_pkg::IRQ_SEL_RESET, dma_sel: ecx_pkg::DMA_SEL_RESET,
            epp_option_cfg: 1'b0};
         st.fault_prev <= 1'b1;
         st.irq_req <= 1'b0;
         st.dma_en <= 1'b0;
         st.port <= '{ctrl_open_drain: 1'b1, fifo_reset_hold: 1'b1, default: 1'b0};
         st.rdata <= '0;
         st.ready <= 1'b0;
         st.slverr <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.rdata;
   assign pready = st.ready;
   assign pslverr = st.slverr;
   assign irq_req = st.irq_req;
   assign dma_enable_out = st.dma_en;
   assign port_ctl = st.port;
   assign mode_out = st.ecr.mode;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic rd_setup;
   assign rd_setup = setup_ph && !pwrite;

   a_irq_level_read: assert property (
      rd_setup && hit_cfgb |=> prdata[6] == $past(st.irq_req))
      else $error("config b bit 6 does not match irq level");
   a_cfgb_upper_zero: assert property (
      rd_setup && hit_cfgb |=> prdata[31:7] == '0)
      else $error("config b upper bits not zero");
   a_irq_code_map: assert property (
      rd_setup && hit_cfgb && st.setup.irq_sel == 4'h5 |=> prdata[5:3] == 3'h7)
      else $error("irq 5 code wrong");
   a_irq_code_top: assert property (
      rd_setup && hit_cfgb && st.setup.irq_sel == 4'hF |=> prdata[5:3] == 3'h6)
      else $error("irq 15 code wrong");
   a_irq_code_other: assert property (
      rd_setup && hit_cfgb && st.setup.irq_sel == 4'h3 |=> prdata[5:3] == 3'h0)
      else $error("unlisted irq code not zero");
   a_dma_code_map: assert property (
      rd_setup && hit_cfgb && st.setup.dma_sel == 2'h3 |=> prdata[2:0] == 3'h3)
      else $error("dma 3 code wrong");
   a_dma_code_none: assert property (
      rd_setup && hit_cfgb && st.setup.dma_sel == 2'h0 |=> prdata[2:0] == 3'h0)
      else $error("unselected dma code not zero");
   a_mode_write: assert property (
      wr_done && hit_ecr |=> mode_out == $past(pwdata[7:5]))
      else $error("mode not taken from write");
   a_ecr_readback: assert property (
      rd_setup && hit_ecr |=> prdata[7:2] == $past(st.ecr) && pready && !pslverr)
      else $error("ecr control bits read back wrong");
   a_fault_edge_irq: assert property (fault_evt |=> irq_req)
      else $error("fault edge gave no interrupt");
   a_fault_blocked: assert property (
      st.ecr.fault_irq_disable_n && !svc_evt && !ack_irq_event && !fault_clr_evt |=> !irq_req)
      else $error("interrupt while fault disabled and idle");
   a_fault_outside_ecp: assert property (
      st.ecr.mode != ecx_pkg::ECX_MODE_ECP && !svc_evt && !ack_irq_event |=> !irq_req)
      else $error("fault interrupt outside ecp mode");
   a_fault_clear_irq: assert property (fault_clr_evt |=> irq_req)
      else $error("clearing fault disable gave no interrupt");
   a_dma_off: assert property (
      !st.ecr.dma_permit || st.ecr.svc_irq_flag |=> !dma_enable_out)
      else $error("dma enabled while blocked");
   a_dma_on: assert property (
      fifo_mode && st.ecr.dma_permit && !st.ecr.svc_irq_flag |=> dma_enable_out)
      else $error("dma not enabled while permitted");
   a_svc_quiet: assert property (
      st.ecr.svc_irq_flag && !fault_evt && !fault_clr_evt && !ack_irq_event |=> !irq_req)
      else $error("service interrupt while service flag set");
   a_svc_write_one: assert property (
      wr_done && hit_ecr && pwdata[ecx_pkg::ECR_SVC_BIT] |=> st.ecr.svc_irq_flag)
      else $error("writing one did not set service flag");
   a_svc_sticky: assert property (
      st.ecr.svc_irq_flag && !(wr_done && hit_ecr) |=> st.ecr.svc_irq_flag)
      else $error("service flag dropped without a write");
   a_svc_clear: assert property (
      wr_done && hit_ecr && !pwdata[ecx_pkg::ECR_SVC_BIT] && !svc_evt |=> !st.ecr.svc_irq_flag)
      else $error("software clear of service flag lost");
   a_svc_tc: assert property (
      fifo_mode && !st.ecr.svc_irq_flag && st.ecr.dma_permit && dma_tc
      |=> st.ecr.svc_irq_flag && irq_req)
      else $error("terminal count did not set service flag");
   a_svc_forward: assert property (
      fifo_mode && !st.ecr.svc_irq_flag && !st.ecr.dma_permit
      && !direction && free_bytes >= st.setup.tx_free_threshold
      |=> st.ecr.svc_irq_flag && irq_req)
      else $error("forward threshold did not set service flag");
   a_svc_reverse: assert property (
      fifo_mode && !st.ecr.svc_irq_flag && !st.ecr.dma_permit
      && direction && fifo_level >= st.setup.rx_fill_threshold
      |=> st.ecr.svc_irq_flag && irq_req)
      else $error("reverse threshold did not set service flag");
   a_full_read: assert property (
      rd_setup && hit_ecr |=> prdata[1] == ($past(fifo_level) >= DEPTH))
      else $error("full bit wrong");
   a_empty_read: assert property (
      rd_setup && hit_ecr |=> prdata[0] == ($past(fifo_level) == '0))
      else $error("empty bit wrong");
   a_fifo_held: assert property (
      st.ecr.mode == ecx_pkg::ECX_MODE_STD
      |=> port_ctl.fifo_reset_hold && port_ctl.ctrl_open_drain && !port_ctl.data_tristate)
      else $error("standard mode does not hold fifo");
   a_bidir_pins: assert property (
      st.ecr.mode == ecx_pkg::ECX_MODE_BIDIR
      |=> port_ctl.data_read_pins && port_ctl.data_tristate == $past(direction))
      else $error("bidirectional mode pin control wrong");
   a_compat_fwd: assert property (
      st.ecr.mode == ecx_pkg::ECX_MODE_FIFO
      |=> port_ctl.auto_tx_compat == !$past(direction) && !port_ctl.data_tristate)
      else $error("fifo mode send control wrong");
   a_ecp_split: assert property (
      st.ecr.mode == ecx_pkg::ECX_MODE_ECP
      |=> port_ctl.auto_tx_ecp == !$past(direction)
      && port_ctl.ecp_rev_pack == $past(direction))
      else $error("ecp mode direction control wrong");
   a_epp_gate: assert property (
      st.ecr.mode == ecx_pkg::ECX_MODE_EPP
      |=> port_ctl.epp_active == $past(st.setup.epp_option_cfg))
      else $error("epp does not follow its option");
   a_epp_other: assert property (
      st.ecr.mode != ecx_pkg::ECX_MODE_EPP |=> !port_ctl.epp_active)
      else $error("epp active outside mode 100");
   a_test_no_tx: assert property (
      st.ecr.mode == ecx_pkg::ECX_MODE_TEST || st.ecr.mode == ecx_pkg::ECX_MODE_RSVD
      |=> !port_ctl.auto_tx_compat && !port_ctl.auto_tx_ecp && !port_ctl.epp_active)
      else $error("test or reserved mode transmits");
   a_cfg_flag: assert property (
      st.ecr.mode == ecx_pkg::ECX_MODE_CFG |=> port_ctl.cfg_mapped)
      else $error("config mode not flagged");
   a_cfga_value: assert property (
      rd_setup && hit_cfga |=> prdata == {24'h0, ecx_pkg::CFG_A_VALUE} && !pslverr)
      else $error("config a value wrong");
   a_cfg_unmapped: assert property (
      rd_setup && !in_cfg && paddr == ecx_pkg::ADDR_CFG_B |=> pready && pslverr && prdata == '0)
      else $error("config b reachable outside config mode");
   a_clear_reissue: assert property (
      wr_done && hit_ecr && st.ecr.svc_irq_flag && !pwdata[ecx_pkg::ECR_SVC_BIT]
      ##1 fifo_mode && svc_cond |=> irq_req)
      else $error("clearing service flag under condition gave no interrupt");
   a_fifo_off: assert property (
      !fifo_mode |=> port_ctl.fifo_reset_hold && !dma_enable_out)
      else $error("fifo enabled outside fifo modes");
   a_ack_irq: assert property (ack_irq_event |=> irq_req)
      else $error("acknowledge event gave no interrupt");

   c_svc_irq: cover property (svc_evt ##1 irq_req);
   c_fault_clear: cover property (fault_clr_evt);
   c_cfg_read: cover property (rd_setup && hit_cfgb);
   c_dma_run: cover property (dma_enable_out ##[1:20] st.ecr.svc_irq_flag);
   c_tc_irq: cover property (dma_tc && dma_enable_out ##1 irq_req);

endmodule : ecx_ext_control

// [include/ecx_pkg.sv]
// constants and carrier types of the extended control block
package ecx_pkg;
   // register indices, byte address is four times the index
   localparam logic [11:0] IDX_CFG_A = 12'h400;
   localparam logic [11:0] IDX_CFG_B = 12'h401;
   localparam logic [11:0] IDX_ECR = 12'h402;
   localparam logic [11:0] IDX_SETUP = 12'h403;
   localparam logic [15:0] ADDR_CFG_A = {2'h0, IDX_CFG_A, 2'h0};
   localparam logic [15:0] ADDR_CFG_B = {2'h0, IDX_CFG_B, 2'h0};
   localparam logic [15:0] ADDR_ECR = {2'h0, IDX_ECR, 2'h0};
   localparam logic [15:0] ADDR_SETUP = {2'h0, IDX_SETUP, 2'h0};
   // ecr field positions
   localparam int ECR_MODE_LSB = 5;
   localparam int ECR_FAULT_BIT = 4;
   localparam int ECR_DMA_BIT = 3;
   localparam int ECR_SVC_BIT = 2;
   localparam int ECR_FULL_BIT = 1;
   localparam int ECR_EMPTY_BIT = 0;
   // config b field positions
   localparam int CFGB_IRQ_LEVEL_BIT = 6;
   localparam int CFGB_IRQ_LSB = 3;
   localparam int CFGB_DMA_LSB = 0;
   // setup register field positions
   localparam int SET_TX_LSB = 0;
   localparam int SET_RX_LSB = 8;
   localparam int SET_IRQ_LSB = 16;
   localparam int SET_DMA_LSB = 20;
   localparam int SET_EPP_BIT = 24;
   // fixed read value and reset values
   localparam logic [7:0] CFG_A_VALUE = 8'h10;
   localparam logic [4:0] THRESHOLD_RESET = 5'h08;
   localparam logic [3:0] IRQ_SEL_RESET = 4'h0;
   localparam logic [1:0] DMA_SEL_RESET = 2'h0;

   typedef enum logic [2:0] {
      ECX_MODE_STD = 3'h0,
      ECX_MODE_BIDIR = 3'h1,
      ECX_MODE_FIFO = 3'h2,
      ECX_MODE_ECP = 3'h3,
      ECX_MODE_EPP = 3'h4,
      ECX_MODE_RSVD = 3'h5,
      ECX_MODE_TEST = 3'h6,
      ECX_MODE_CFG = 3'h7
   } ecx_mode_t;

   typedef struct packed {
      ecx_mode_t mode;
      logic fault_irq_disable_n;
      logic dma_permit;
      logic svc_irq_flag;
   } ecx_ecr_t;

   localparam ecx_ecr_t ECR_RESET = '{mode: ECX_MODE_STD, fault_irq_disable_n: 1'b1,
      dma_permit: 1'b0, svc_irq_flag: 1'b1};

   typedef struct packed {
      logic [4:0] tx_free_threshold;
      logic [4:0] rx_fill_threshold;
      logic [3:0] irq_sel;
      logic [1:0] dma_sel;
      logic epp_option_cfg;
   } ecx_setup_t;

   typedef struct packed {
      logic ctrl_open_drain;
      logic data_tristate;
      logic data_read_pins;
      logic auto_tx_compat;
      logic auto_tx_ecp;
      logic ecp_rev_pack;
      logic epp_active;
      logic test_fifo;
      logic cfg_mapped;
      logic fifo_reset_hold;
   } ecx_port_t;
endpackage : ecx_pkg

// [verification/ecx_printer_model.sv]
// printer side model driving the fault line
`timescale 1ns/1ps
module ecx_printer_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fault_req,
   output logic periph_error_n
);
   // fault line idles high, low while the printer reports an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_error_n <= 1'b1;
      end else begin
         periph_error_n <= !fault_req;
      end
   end
endmodule : ecx_printer_model

// [verification/testbench.sv]
// apb driven bench for the extended control block
`timescale 1ns/1ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, periph_error_n;
   logic ack_irq_event, dma_tc, direction, irq_req, dma_enable_out, fault_req;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [4:0] fifo_level;
   ecx_pkg::ecx_port_t port_ctl;
   ecx_pkg::ecx_mode_t mode_out;
   int mismatches = 0;
   int compares = 0;
   int irq_cnt = 0;
   int irq_mark = 0;
   logic [3:0] irq_num [8] = '{4'hF, 4'hE, 4'hB, 4'hA, 4'h9, 4'h7, 4'h5, 4'h3};
   logic [2:0] irq_code [8] = '{3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h7, 3'h0};

   ecx_ext_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_error_n(periph_error_n), .ack_irq_event(ack_irq_event),
      .dma_tc(dma_tc), .direction(direction), .fifo_level(fifo_level), .irq_req(irq_req),
      .dma_enable_out(dma_enable_out), .port_ctl(port_ctl), .mode_out(mode_out));
   ecx_printer_model partner (.pclk(pclk), .presetn(presetn), .fault_req(fault_req),
      .periph_error_n(periph_error_n));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) if (irq_req === 1'b1) irq_cnt <= irq_cnt + 1;

   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask : idle

   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask : wr

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      chk(rd, exp);
      chk({31'h0, err}, {31'h0, exp_err});
   endtask : rd_chk

   task automatic irqs(input int n);
      idle(4);
      chk(32'(irq_cnt - irq_mark), 32'(n));
      irq_mark = irq_cnt;
   endtask : irqs

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, ack_irq_event, dma_tc, fault_req} = '0;
      paddr = 16'h0000;
      pwdata = 32'h0;
      direction = 1'b1;
      fifo_level = 5'h00;
      idle(5);
      presetn <= 1'b1;
      idle(1);
      rd_chk(ecx_pkg::ADDR_ECR, 32'h15, 1'b0);
      chk({30'h0, port_ctl.ctrl_open_drain, port_ctl.fifo_reset_hold}, 32'h3);
      chk({31'h0, port_ctl.data_tristate}, 32'h0);
      rd_chk(ecx_pkg::ADDR_CFG_B, 32'h0, 1'b1);
      rd_chk(16'h1010, 32'h0, 1'b1);
      // config mode readback of irq and dma codes
      wr(ecx_pkg::ADDR_ECR, 32'hF4);
      rd_chk(ecx_pkg::ADDR_CFG_A, 32'h10, 1'b0);
      chk({31'h0, port_ctl.cfg_mapped}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         wr(ecx_pkg::ADDR_SETUP, {10'h0, 2'(3 - i % 4), irq_num[i], 16'h0808});
         rd_chk(ecx_pkg::ADDR_CFG_B, {26'h0, irq_code[i], 3'(3 - i % 4)}, 1'b0);
      end
      // fault interrupt in ecp mode, direction turned only in mode 001
      // legal mode path
      wr(ecx_pkg::ADDR_ECR, 32'h34);
      direction <= 1'b0;
      wr(ecx_pkg::ADDR_ECR, 32'h74);
      fault_req <= 1'b1;
      irqs(0);
      chk({30'h0, port_ctl.auto_tx_ecp, port_ctl.ecp_rev_pack}, 32'h2);
      chk({29'h0, mode_out}, 32'h3);
      wr(ecx_pkg::ADDR_ECR, 32'h64);
      irqs(1);
      fault_req <= 1'b0;
      irqs(0);
      fault_req <= 1'b1;
      irqs(1);
      fault_req <= 1'b0;
      // forward service interrupt on free space
      wr(ecx_pkg::ADDR_ECR, 32'h34);
      fifo_level <= 5'h10;
      wr(ecx_pkg::ADDR_ECR, 32'h54);
      wr(ecx_pkg::ADDR_ECR, 32'h50);
      irqs(0);
      chk({31'h0, port_ctl.auto_tx_compat}, 32'h1);
      rd_chk(ecx_pkg::ADDR_ECR, 32'h52, 1'b0);
      fifo_level <= 5'h08;
      irqs(1);
      rd_chk(ecx_pkg::ADDR_ECR, 32'h54, 1'b0);
      wr(ecx_pkg::ADDR_ECR, 32'h50);
      irqs(1);
      // dma terminal count
      wr(ecx_pkg::ADDR_ECR, 32'h58);
      irqs(0);
      chk({31'h0, dma_enable_out}, 32'h1);
      dma_tc <= 1'b1;
      idle(1);
      dma_tc <= 1'b0;
      irqs(1);
      rd_chk(ecx_pkg::ADDR_ECR, 32'h5C, 1'b0);
      chk({31'h0, dma_enable_out}, 32'h0);
      // reverse service interrupt in test mode
      wr(ecx_pkg::ADDR_ECR, 32'h34);
      direction <= 1'b1;
      idle(2);
      chk({30'h0, port_ctl.data_tristate, port_ctl.data_read_pins}, 32'h3);
      fifo_level <= 5'h07;
      wr(ecx_pkg::ADDR_ECR, 32'hD4);
      wr(ecx_pkg::ADDR_ECR, 32'hD0);
      irqs(0);
      chk({31'h0, port_ctl.test_fifo}, 32'h1);
      chk({30'h0, port_ctl.auto_tx_compat, port_ctl.auto_tx_ecp}, 32'h0);
      fifo_level <= 5'h08;
      irqs(1);
      wr(ecx_pkg::ADDR_ECR, 32'hD4);
      irqs(0);
      // epp option and acknowledge interrupt
      wr(ecx_pkg::ADDR_ECR, 32'h34);
      direction <= 1'b0;
      wr(ecx_pkg::ADDR_SETUP, 32'h0100_0808);
      wr(ecx_pkg::ADDR_ECR, 32'h94);
      idle(2);
      chk({31'h0, port_ctl.epp_active}, 32'h1);
      ack_irq_event <= 1'b1;
      idle(1);
      ack_irq_event <= 1'b0;
      irqs(1);
      end_sim();
   end
endmodule : testbench
